// *** verilog/eea_pkg.sv ***
// constants and types for the data eeprom access controller
package eea_pkg;
    // special function register addresses
    localparam logic [11:0] OFF_CTRL       = 12'hFA6;
    localparam logic [11:0] OFF_KEY        = 12'hFA7;
    localparam logic [11:0] OFF_DATA       = 12'hFA8;
    localparam logic [11:0] OFF_ADDR_LOW   = 12'hFA9;
    localparam logic [11:0] OFF_ADDR_HIGH  = 12'hFAA;
    localparam logic [11:0] OFF_FLAG_TWO   = 12'hFA1;

    // nv_access_control field positions
    localparam int BIT_PROG_SEL   = 7;
    localparam int BIT_CFG_SEL    = 6;
    localparam int BIT_SIG_SEL    = 5;
    localparam int BIT_ROW_ERASE  = 4;
    localparam int BIT_WR_ERROR   = 3;
    localparam int BIT_WR_UNLOCK  = 2;
    localparam int BIT_WR_START   = 1;
    localparam int BIT_RD_START   = 0;
    // write_done_flag position in peripheral_flag_reg_two
    localparam int BIT_WR_DONE    = 4;

    // reset values
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] DATA_RESET     = 8'h00;
    localparam logic [7:0] ADDR_RESET     = 8'h00;

    // unlock keys and erased cell value
    localparam logic [7:0] KEY_FIRST      = 8'h55;
    localparam logic [7:0] KEY_SECOND     = 8'hAA;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;

    // array geometry
    localparam int MEM_DEPTH      = 512;
    localparam int MEM_ADDR_W     = 9;

    // timing at a 5 ns clock
    localparam int CLK_PERIOD_PS  = 5000;
    localparam longint PWRT_TIME_MS = 72;
    localparam longint PWRT_CYC   = (PWRT_TIME_MS * 1000000000) / CLK_PERIOD_PS;
    localparam int ERASE_TIME_NS  = 100;
    localparam int PROG_TIME_NS   = 100;
    localparam int ERASE_CYC      = (ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PROG_CYC       = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PWRT_W         = 24;
    localparam int WT_W           = 16;

    // self-timed write sequencer
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG  = 2'b10,
        ST_OTHER = 2'b11
    } eea_wstate_type;

    // progress through the unlock keys
    typedef enum logic [1:0] {
        UL_IDLE  = 2'b00,
        UL_FIRST = 2'b01,
        UL_READY = 2'b10
    } eea_unlock_type;

    // one core access to the register file
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } eea_sfr_req_type;
endpackage

// *** verilog/eea_mem.sv ***
// byte array with one write port and a registered read port
`timescale 1ns/10ps
module eea_mem #(
    parameter int DEPTH  = 512,
    parameter int ADDR_W = 9
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // write port
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    // read port
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_data
);
    logic [7:0] cell_mem [DEPTH];

    // cells hold no reset, as a real array keeps its contents
    always_ff @(posedge clk) begin
        if (wr_en) begin
            cell_mem[wr_addr] <= wr_data;
        end
    end

    // read data leaves through a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= cell_mem[rd_addr];
        end
    end
endmodule // eea_mem

// *** verilog/eea_ctrl.sv ***
// data eeprom access controller behind the core's special function registers
// Function
// - one byte moves per read or write
// - nine address bits reach 512 locations
// - write erases first, then programs, self-timed
// - key port stores nothing, reads zero
// - start bits set by software, cleared by hardware
// - unlock enable cleared only by software or at power-up
// - reset during write sets write error flag
// - that reset zeroes data and address registers
// - write completion sets done flag, software clears
// - bits seven to five select memory space
// - row erase bit used, cleared when a non-array write completes
// - read start ignored while program space selected
// - read lands next cycle, start self-clears
// - data register holds last read or write
// - keys 55h then AAh precede write start
// - unlock enable must precede write start instruction
// - clearing unlock enable never aborts a write
// - no writes during power-up timer
`timescale 1ns/10ps
module eea_ctrl import eea_pkg::*; #(
    parameter longint PWRT_CYCLES  = PWRT_CYC,
    parameter int     ERASE_CYCLES = ERASE_CYC,
    parameter int     PROG_CYCLES  = PROG_CYC
) (
    // clock and power-on reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // other reset sources
    input  wire logic            master_clear_pin_b,
    input  wire logic            wdt_reset,
    // core register access
    input  wire eea_sfr_req_type sfr_req,
    output logic      [7:0]      sfr_rdata,
    // status toward the core
    output logic                 write_done_flag,
    output logic                 write_busy
);
    logic [7:0]            data_reg;
    logic [7:0]            addr_low_reg;
    logic                  addr_high_reg;
    logic                  prog_sel_reg, cfg_sel_reg, sig_sel_reg, row_erase_reg;
    logic                  write_error_flag_reg, write_unlock_enable_reg, wr_reg, rd_reg;
    logic                  done_reg;
    eea_unlock_type        ul_reg;
    eea_wstate_type        state_reg;
    logic [WT_W-1:0]       wt_cnt_reg;
    logic [PWRT_W-1:0]     pwrt_cnt_reg;
    logic                  pwrt_done;
    logic [7:0]            wdata_lat_reg;
    logic [MEM_ADDR_W-1:0] waddr_lat_reg;
    logic [2:0]            master_clear_pin_sync_reg;
    logic                  master_clear_pin_lvl_reg;
    logic                  sys_rst;
    logic                  ctrl_wr, key_wr, data_wr, addrl_wr, addrh_wr, flag_wr;
    logic                  rd_set, wr_set, space_eeprom, phase_end;
    logic                  mem_we, mem_re;
    logic [7:0]            mem_wdata, mem_rdata;
    logic [MEM_ADDR_W-1:0] cur_addr;

    // address compare shared by every register decode
    function automatic logic sfr_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // last counter value of a timed phase, cycles minus one, never below zero
    function automatic logic [WT_W-1:0] phase_last(input int cycles);
        return (cycles > 1) ? WT_W'(cycles - 1) : '0;
    endfunction

    assign ctrl_wr  = sfr_req.wr && sfr_hit(sfr_req.addr, OFF_CTRL);
    assign key_wr   = sfr_req.wr && sfr_hit(sfr_req.addr, OFF_KEY);
    assign data_wr  = sfr_req.wr && sfr_hit(sfr_req.addr, OFF_DATA);
    assign addrl_wr = sfr_req.wr && sfr_hit(sfr_req.addr, OFF_ADDR_LOW);
    assign addrh_wr = sfr_req.wr && sfr_hit(sfr_req.addr, OFF_ADDR_HIGH);
    assign flag_wr  = sfr_req.wr && sfr_hit(sfr_req.addr, OFF_FLAG_TWO);
    assign cur_addr = {addr_high_reg, addr_low_reg};

    // master clear pin: three flops, level moves once the last two agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            master_clear_pin_sync_reg <= 3'b111;
            master_clear_pin_lvl_reg  <= 1'b1;
        end else begin
            master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[1:0], master_clear_pin_b};
            if (master_clear_pin_sync_reg[1] == master_clear_pin_sync_reg[2]) begin
                master_clear_pin_lvl_reg <= master_clear_pin_sync_reg[2];
            end
        end
    end

    // held pin or a watchdog expiry acts as a reset for this block
    assign sys_rst = !master_clear_pin_lvl_reg || wdt_reset;

    // power-up timer runs once after power-on, then stays done
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrt_cnt_reg <= '0;
        end else if (!pwrt_done) begin
            pwrt_cnt_reg <= pwrt_cnt_reg + 1'b1;
        end
    end
    assign pwrt_done = (pwrt_cnt_reg >= PWRT_W'(PWRT_CYCLES));

    // space bits seven to five must be clear for an array access
    assign space_eeprom = !prog_sel_reg && !cfg_sel_reg && !sig_sel_reg;

    // a read may not start with program space chosen by this same write
    assign rd_set = ctrl_wr && sfr_req.wdata[BIT_RD_START]
                    && !sfr_req.wdata[BIT_PROG_SEL] && !sys_rst;

    // write start needs the key pair, an earlier enable and an idle sequencer
    assign wr_set = ctrl_wr && sfr_req.wdata[BIT_WR_START] && !wr_reg
                    && write_unlock_enable_reg
                    && (ul_reg == UL_READY)
                    && pwrt_done
                    && (state_reg == ST_IDLE) && !sys_rst;

    // unlock tracker: 55h then AAh on the key port arms one write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ul_reg <= UL_IDLE;
        end else if (sys_rst || ctrl_wr) begin
            ul_reg <= UL_IDLE; // one write per key pair
        end else if (key_wr) begin
            if (sfr_req.wdata == KEY_FIRST) begin
                ul_reg <= UL_FIRST;
            end else if (sfr_req.wdata == KEY_SECOND && ul_reg == UL_FIRST) begin
                ul_reg <= UL_READY;
            end else begin
                ul_reg <= UL_IDLE;
            end
        end
    end

    // end of the current timed phase
    always_comb begin
        unique case (state_reg)
            ST_ERASE: phase_end = (wt_cnt_reg == phase_last(ERASE_CYCLES));
            ST_PROG:  phase_end = (wt_cnt_reg == phase_last(PROG_CYCLES));
            ST_OTHER: phase_end = (wt_cnt_reg == phase_last(ERASE_CYCLES));
            ST_IDLE:  phase_end = 1'b0;
        endcase
    end

    // self-timed sequencer: erase the byte, then program it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= ST_IDLE;
            wt_cnt_reg <= '0;
        end else if (sys_rst) begin
            state_reg  <= ST_IDLE;
            wt_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    wt_cnt_reg <= '0;
                    if (wr_set) begin
                        state_reg <= space_eeprom ? ST_ERASE : ST_OTHER;
                    end
                end
                ST_ERASE: begin
                    wt_cnt_reg <= phase_end ? '0 : wt_cnt_reg + 1'b1;
                    if (phase_end) begin
                        state_reg <= ST_PROG;
                    end
                end
                ST_PROG, ST_OTHER: begin
                    wt_cnt_reg <= phase_end ? '0 : wt_cnt_reg + 1'b1;
                    if (phase_end) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // target byte is frozen at start so register edits cannot corrupt it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdata_lat_reg <= DATA_RESET;
            waddr_lat_reg <= '0;
        end else if (wr_set) begin
            wdata_lat_reg <= data_reg;
            waddr_lat_reg <= cur_addr;
        end
    end

    // array port: erase phase stores the blank value, program the data
    assign mem_we    = phase_end && !sys_rst
                       && (state_reg == ST_ERASE || state_reg == ST_PROG);
    assign mem_wdata = (state_reg == ST_ERASE) ? ERASED_BYTE : wdata_lat_reg;
    assign mem_re    = rd_set;

    // control register, space and enable fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_sel_reg  <= CTRL_RESET[BIT_PROG_SEL];
            cfg_sel_reg   <= CTRL_RESET[BIT_CFG_SEL];
            sig_sel_reg   <= CTRL_RESET[BIT_SIG_SEL];
            row_erase_reg <= CTRL_RESET[BIT_ROW_ERASE];
            write_unlock_enable_reg      <= CTRL_RESET[BIT_WR_UNLOCK];
        end else begin
            if (ctrl_wr) begin
                prog_sel_reg <= sfr_req.wdata[BIT_PROG_SEL];
                cfg_sel_reg  <= sfr_req.wdata[BIT_CFG_SEL];
                sig_sel_reg  <= sfr_req.wdata[BIT_SIG_SEL];
                write_unlock_enable_reg     <= sfr_req.wdata[BIT_WR_UNLOCK];
            end
            // completing a non-array cycle consumes the row erase request
            if (state_reg == ST_OTHER && phase_end && !sys_rst) begin
                row_erase_reg <= 1'b0;
            end else if (ctrl_wr) begin
                row_erase_reg <= sfr_req.wdata[BIT_ROW_ERASE];
            end
        end
    end

    // start bits: software may only set, hardware clears on completion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            if (sys_rst || (phase_end && state_reg != ST_ERASE)) begin
                wr_reg <= 1'b0;
            end else if (wr_set) begin
                wr_reg <= 1'b1;
            end
            rd_reg <= rd_set;
        end
    end

    // error flag: an interrupted write wins over a software clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_error_flag_reg <= CTRL_RESET[BIT_WR_ERROR];
        end else if (sys_rst && state_reg != ST_IDLE) begin
            write_error_flag_reg <= 1'b1;
        end else if (ctrl_wr) begin
            write_error_flag_reg <= sfr_req.wdata[BIT_WR_ERROR];
        end
    end

    // done flag: set on completion beats a same-cycle clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
        end else if (phase_end && !sys_rst && state_reg != ST_ERASE) begin
            done_reg <= 1'b1;
        end else if (flag_wr) begin
            done_reg <= sfr_req.wdata[BIT_WR_DONE];
        end
    end

    // data register holds the last read or the last software value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_reg <= DATA_RESET;
        end else if (sys_rst) begin
            data_reg <= DATA_RESET;
        end else if (rd_reg && space_eeprom) begin
            data_reg <= mem_rdata;
        end else if (data_wr) begin
            data_reg <= sfr_req.wdata;
        end
    end

    // address pair, only bit zero of the high half exists
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_low_reg  <= ADDR_RESET;
            addr_high_reg <= 1'b0;
        end else if (sys_rst) begin
            addr_low_reg  <= ADDR_RESET;
            addr_high_reg <= 1'b0;
        end else begin
            if (addrl_wr) begin
                addr_low_reg <= sfr_req.wdata;
            end
            if (addrh_wr) begin
                addr_high_reg <= sfr_req.wdata[0];
            end
        end
    end

    // read mux; registered so the core sees it the cycle after its strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            if (sfr_hit(sfr_req.addr, OFF_CTRL)) begin
                sfr_rdata <= {prog_sel_reg, cfg_sel_reg, sig_sel_reg, row_erase_reg,
                              write_error_flag_reg, write_unlock_enable_reg, wr_reg, rd_reg};
            end else if (sfr_hit(sfr_req.addr, OFF_DATA)) begin
                sfr_rdata <= data_reg;
            end else if (sfr_hit(sfr_req.addr, OFF_ADDR_LOW)) begin
                sfr_rdata <= addr_low_reg;
            end else if (sfr_hit(sfr_req.addr, OFF_ADDR_HIGH)) begin
                sfr_rdata <= {7'h00, addr_high_reg};
            end else if (sfr_hit(sfr_req.addr, OFF_FLAG_TWO)) begin
                sfr_rdata <= 8'(done_reg) << BIT_WR_DONE;
            end else begin
                sfr_rdata <= 8'h00; // key port and unmapped
            end
        end
    end

    assign write_done_flag = done_reg;
    assign write_busy      = wr_reg;

    // the byte array itself
    eea_mem #(
        .DEPTH  (MEM_DEPTH),
        .ADDR_W (MEM_ADDR_W)
    ) u_mem (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (mem_we),
        .wr_addr (waddr_lat_reg),
        .wr_data (mem_wdata),
        .rd_en   (mem_re),
        .rd_addr (cur_addr),
        .rd_data (mem_rdata)
    );

    // checks on the sequencing above
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_array_go;
        wr_set && space_eeprom;
    endsequence
    sequence s_erase_begins;
        ##1 (state_reg == ST_ERASE && wt_cnt_reg == '0 && wr_reg);
    endsequence

    a_rd_self_clear: assert property (rd_reg && !rd_set |=> !rd_reg)
        else $error("read start did not clear after one cycle");
    a_rd_pgd_block: assert property (ctrl_wr && sfr_req.wdata[BIT_PROG_SEL] |=> !rd_reg)
        else $error("read started with program space selected");
    a_key_reads_zero: assert property (sfr_req.rd && sfr_hit(sfr_req.addr, OFF_KEY)
        |=> sfr_rdata == 8'h00)
        else $error("key port read returned nonzero");
    a_wr_needs_write_unlock_enable: assert property ($rose(wr_reg) |-> $past(write_unlock_enable_reg) && $past(pwrt_done))
        else $error("write started without earlier enable or during power-up");
    a_wr_needs_keys: assert property ($rose(wr_reg) |-> $past(ul_reg) == UL_READY)
        else $error("write started without the key pair");
    a_bad_key_reset: assert property (key_wr && sfr_req.wdata != KEY_FIRST
        && !(sfr_req.wdata == KEY_SECOND && ul_reg == UL_FIRST) |=> ul_reg == UL_IDLE)
        else $error("wrong key left the unlock armed");
    a_wr_starts_erase: assert property (s_array_go |-> s_erase_begins)
        else $error("array write did not begin with erase");
    a_erase_blank: assert property (mem_we && state_reg == ST_ERASE
        |-> mem_wdata == ERASED_BYTE ##1 state_reg == ST_PROG)
        else $error("erase phase did not blank then program");
    a_wr_held: assert property (wr_reg && !phase_end && !sys_rst |=> wr_reg)
        else $error("write start dropped before completion");
    a_done_set: assert property (state_reg == ST_PROG && phase_end && !sys_rst
        |=> done_reg && !wr_reg && state_reg == ST_IDLE)
        else $error("completion did not set done and clear start");
    a_abort_error: assert property (sys_rst && state_reg != ST_IDLE
        |=> write_error_flag_reg && data_reg == 8'h00 && cur_addr == '0 && !wr_reg)
        else $error("interrupted write not flagged or registers not cleared");
    a_write_unlock_enable_kept: assert property (write_unlock_enable_reg && !ctrl_wr |=> write_unlock_enable_reg)
        else $error("unlock enable cleared by hardware");
    a_data_hold: assert property (!rd_reg && !data_wr && !sys_rst |=> $stable(data_reg))
        else $error("data register changed without cause");
endmodule // eea_ctrl

// *** tb/eea_ctrl_bench.sv ***
// self-checking bench for the data eeprom access controller
`timescale 1ns/10ps
module eea_ctrl_bench import eea_pkg::*;;
    logic            clk;
    logic            rst_b;
    logic            master_clear_pin_b;
    logic            wdt_reset;
    eea_sfr_req_type sfr_req;
    logic [7:0]      sfr_rdata;
    logic            write_done_flag;
    logic            write_busy;
    int              err_count;
    int              checked;
    int              cycles;
    logic [7:0]      mem_model [MEM_DEPTH];
    logic [8:0]      addr_list [6];
    logic [7:0]      rv;

    // short lockout and timer so the run stays small; program phase longer than reset latency
    eea_ctrl #(.PWRT_CYCLES(16), .ERASE_CYCLES(3), .PROG_CYCLES(8)) eea_ctrl_i (
        .clk                (clk),
        .rst_b              (rst_b),
        .master_clear_pin_b (master_clear_pin_b),
        .wdt_reset          (wdt_reset),
        .sfr_req            (sfr_req),
        .sfr_rdata          (sfr_rdata),
        .write_done_flag    (write_done_flag),
        .write_busy         (write_busy)
    );

    // 200 mhz clock
    always #2.5 clk = ~clk;

    // verdict and end of run
    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // expected control byte with no space bits and no start bits
    function automatic logic [7:0] ctrl_exp(input logic en, input logic err);
        return {4'h0, err, en, 2'b00};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
            err_count++;
        end
    endtask

    // one access then an idle cycle, so a strobe is never raised twice in one step
    task automatic access(input logic [11:0] a, input logic w, input logic [7:0] d);
        sfr_req = {a, w, ~w, d};
        @(negedge clk);
        sfr_req = '0;
        @(negedge clk);
    endtask

    task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string what);
        access(a, 1'b0, 8'h00);
        check(sfr_rdata, exp, what);
    endtask

    task automatic load(input logic [8:0] a, input logic [7:0] d);
        access(OFF_ADDR_LOW, 1'b1, a[7:0]);
        access(OFF_ADDR_HIGH, 1'b1, {7'h00, a[8]});
        access(OFF_DATA, 1'b1, d);
    endtask

    // enable write, two keys, then the start attempt
    task automatic arm(input logic [7:0] en, input logic [7:0] k1, input logic [7:0] k2,
                       input logic [7:0] c);
        access(OFF_CTRL, 1'b1, en);
        access(OFF_KEY, 1'b1, k1);
        access(OFF_KEY, 1'b1, k2);
        access(OFF_CTRL, 1'b1, c);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, write_busy}, 8'h00, "write never finished");
    endtask

    task automatic read_at(input logic [8:0] a, input logic [7:0] exp);
        access(OFF_ADDR_LOW, 1'b1, a[7:0]);
        access(OFF_ADDR_HIGH, 1'b1, {7'h00, a[8]});
        access(OFF_CTRL, 1'b1, 8'h01);
        reg_rd(OFF_DATA, exp, "read data");
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        master_clear_pin_b = 1'b1;
        wdt_reset = 1'b0;
        sfr_req = '0;
        err_count = 0;
        checked = 0;
        cycles = 0;
        void'($urandom(32'hF5CA5142));
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        // a correct sequence inside the power-up lockout must be refused
        arm(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
        check({7'h00, write_busy}, 8'h00, "write in lockout");
        reg_rd(OFF_CTRL, ctrl_exp(1'b1, 1'b0), "ctrl after lockout");
        reg_rd(OFF_KEY, 8'h00, "key port read");
        reg_rd(12'hFA5, 8'h00, "unmapped read");
        $display("test lockout done");
        repeat (20) @(negedge clk);
        // corner and random byte writes
        for (int i = 0; i < 6; i++) begin
            addr_list[i] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : (i == 2) ? 9'h100
                         : 9'($urandom);
            rv = 8'($urandom);
            mem_model[addr_list[i]] = rv;
            load(addr_list[i], rv);
            arm(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
            check({7'h00, write_busy}, 8'h01, "write started");
            wait_idle();
            check({7'h00, write_done_flag}, 8'h01, "done flag set");
            reg_rd(OFF_CTRL, ctrl_exp(1'b1, 1'b0), "ctrl after write");
            access(OFF_FLAG_TWO, 1'b1, 8'h00);
            check({7'h00, write_done_flag}, 8'h00, "done flag cleared");
        end
        // read back every written location; the address bit 8 corners tell 000 from 100
        for (int i = 0; i < 6; i++) begin
            read_at(addr_list[i], mem_model[addr_list[i]]);
        end
        reg_rd(OFF_CTRL, 8'h00, "read start cleared");
        reg_rd(OFF_DATA, mem_model[addr_list[5]], "data held");
        $display("test write and read done");
        // broken sequences: same-write enable, swapped keys, wrong second key
        for (int i = 0; i < 3; i++) begin
            arm((i == 0) ? 8'h00 : 8'h04, (i == 1) ? KEY_SECOND : KEY_FIRST,
                (i == 1) ? KEY_FIRST : (i == 2) ? 8'h5A : KEY_SECOND, 8'h06);
            check({7'h00, write_busy}, 8'h00, "bad sequence started");
        end
        access(OFF_CTRL, 1'b1, 8'h06);
        check({7'h00, write_busy}, 8'h00, "stale unlock started");
        $display("test refusals done");
        // clearing enable and start bits mid-write leaves the cycle intact
        load(9'h0A5, 8'hC3);
        arm(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
        access(OFF_CTRL, 1'b1, 8'h00);
        check({7'h00, write_busy}, 8'h01, "write aborted by software");
        wait_idle();
        access(OFF_FLAG_TWO, 1'b1, 8'h00);
        read_at(9'h0A5, 8'hC3);
        // program space selected: read start ignored, data unchanged
        access(OFF_CTRL, 1'b1, 8'h81);
        reg_rd(OFF_CTRL, 8'h80, "read start with program space");
        reg_rd(OFF_DATA, 8'hC3, "data after ignored read");
        // program space write: timed dummy cycle only, array untouched, row erase consumed
        access(OFF_DATA, 1'b1, 8'h3C);
        arm(8'h94, KEY_FIRST, KEY_SECOND, 8'h96);
        check({7'h00, write_busy}, 8'h01, "program space write started");
        wait_idle();
        check({7'h00, write_done_flag}, 8'h01, "program space done");
        reg_rd(OFF_CTRL, 8'h84, "row erase cleared");
        access(OFF_FLAG_TWO, 1'b1, 8'h00);
        access(OFF_CTRL, 1'b1, 8'h00);
        read_at(9'h0A5, 8'hC3);
        access(OFF_CTRL, 1'b1, 8'h00);
        $display("test mid-write and space select done");
        // watchdog then pin reset during a write
        for (int s = 0; s < 2; s++) begin
            load(9'h133, 8'h5E);
            arm(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
            if (s == 0) begin
                wdt_reset = 1'b1;
            end else begin
                master_clear_pin_b = 1'b0;
            end
            repeat (6) @(negedge clk);
            wdt_reset = 1'b0;
            master_clear_pin_b = 1'b1;
            repeat (6) @(negedge clk);
            reg_rd(OFF_CTRL, ctrl_exp(1'b1, 1'b1), "error flag");
            reg_rd(OFF_DATA, DATA_RESET, "data zeroed");
            reg_rd(OFF_ADDR_LOW, ADDR_RESET, "addr low zeroed");
            reg_rd(OFF_ADDR_HIGH, ADDR_RESET, "addr high zeroed");
            access(OFF_CTRL, 1'b1, 8'h00);
        end
        $display("test interrupted write done");
        complete_run();
    end
endmodule // eea_ctrl_bench
